//--- core/capture_timer.sv
// Capture timer: 16-bit counter with periodic, timeout and capture modes.
// Notes on behaviour
// (RULE_01) Counter and capture/compare value are both 16 bits wide.
// (RULE_02) Eight selectable modes, exactly one active at a time.
// (RULE_03) Counts on local prescaled clock or companion timer's prescaled tick.
// (RULE_04) Debug halt stops counting unless run_while_halted is one.
// (RULE_05) BOTTOM is zero, MAX all ones, TOP the highest count value.
// (RULE_06) Reset selects periodic interrupt mode.
// (RULE_07) Enable starts counting at the selected rate; count is readable.
// (RULE_08) Periodic mode counts to compare value, flags equality, restarts at zero.
// (RULE_09) Periodic mode with TOP below count runs to MAX, wraps, no flag.
// (RULE_10) Timeout mode wraps at MAX; first edge restarts, second edge stops.
// (RULE_11) Timeout mode flags when count reaches TOP before the second edge.
// (RULE_12) Timeout mode: a frozen counter restarts on a new edge.
// (RULE_13) When frozen, register reads and status writes leave counter unchanged.
// (RULE_14) Capture-on-event runs BOTTOM to MAX, copies count on event, flags.
// (RULE_15) Capture edge selectable as rising or falling.
// (RULE_16) Reading capture high byte clears the flag in capture modes.
// (RULE_17) Software should zero the count when entering capture-on-event mode.
// (RULE_18) Event pulses must last longer than one clock cycle.
// (RULE_19) Frequency mode captures, restarts and flags on each selected edge.
// (RULE_20) Pulse width mode restarts on rise, captures on fall, then flags.
// (RULE_21) Pulse width edges must be at least two clock cycles apart.
// (RULE_22) A readable status bit shows whether the counter is counting.
// (RULE_23) Interrupt request follows the flag, high while it is set.
`timescale 1ns/10ps
module capture_timer
   import capture_timer_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // Register port.
   input wire logic [capture_timer_pkg::ADDR_W-1:0] addr_i,
   input wire logic [capture_timer_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [capture_timer_pkg::DATA_W-1:0] rdata_o,
   // System inputs.
   input wire logic event_i,
   input wire logic companion_tick_i,
   input wire logic debug_halt_i,
   // Interrupt request.
   output logic irq_o
);
   import capture_timer_pkg::*;

   tick_if tk ();
   tick_if ev ();

   logic enable;
   logic [1:0] clock_prescale_select;
   mode_t mode;
   logic edge_falling;
   logic run_while_halted;
   logic [CNT_W-1:0] count_value;
   logic [CNT_W-1:0] capture_compare_value;
   logic flag;
   logic counting;
   logic armed;
   logic frqpw_done;
   logic halt_sync1;
   logic halt_sync2;
   pw_state_t pw_state;
   logic run;
   logic sel_edge;
   logic capture_now;
   logic restart_now;
   logic flag_set;
   logic flag_clr;
   logic [CNT_W-1:0] next_count;
   logic [DATA_W-1:0] next_rdata;

   function automatic logic is_capture_mode(input mode_t m);
      return (m == MODE_CAPT_EVENT) || (m == MODE_CAPT_FREQ) ||
             (m == MODE_CAPT_PW) || (m == MODE_CAPT_FRQPW);
   endfunction

   function automatic logic wr_at(input logic [ADDR_W-1:0] ofs);
      return wr_i && (addr_i == ofs);
   endfunction

   // Debug halt arrives from outside this clock; two stages before use.
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         halt_sync1 <= 1'b0;
         halt_sync2 <= 1'b0;
      end else begin
         halt_sync1 <= debug_halt_i;
         halt_sync2 <= halt_sync1;
      end
   end

   assign run = enable && (!halt_sync2 || run_while_halted); // [RULE_04] [RULE_07]

   count_prescaler u_prescaler (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .run_i(run),
      .clock_prescale_select_i(clock_prescale_select),
      .companion_tick_i(companion_tick_i),
      .tk(tk.src)
   );

   event_edge_detect u_edge (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .event_i(event_i),
      .ev(ev.src)
   );

   // Selected edge of the event input. [RULE_15]
   assign sel_edge = run && (edge_falling ? ev.fall : ev.rise);

   // Configuration registers. [RULE_02]
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         enable <= CONTROL_A_RST[ENABLE_BIT];
         clock_prescale_select <= CONTROL_A_RST[CLOCK_PRESCALE_SELECT_LSB +: CLOCK_PRESCALE_SELECT_W];
         mode <= mode_t'(CONTROL_B_RST[MODE_LSB +: MODE_W]); // [RULE_06]
         edge_falling <= CONTROL_B_RST[EDGE_BIT];
         run_while_halted <= 1'b0;
      end else begin
         if (wr_at(CONTROL_A_OFS)) begin
            enable <= wdata_i[ENABLE_BIT];
            clock_prescale_select <= wdata_i[CLOCK_PRESCALE_SELECT_LSB +: CLOCK_PRESCALE_SELECT_W];
         end
         if (wr_at(CONTROL_B_OFS)) begin
            mode <= mode_t'(wdata_i[MODE_LSB +: MODE_W]);
            edge_falling <= wdata_i[EDGE_BIT];
         end
         if (wr_at(DEBUG_CONTROL_OFS)) begin
            run_while_halted <= wdata_i[RUN_WHILE_HALTED_BIT];
         end
      end
   end

   // Pulse width tracker: rise restarts, following fall captures. [RULE_20] [RULE_21]
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pw_state <= PW_IDLE;
      end else if (!run || (mode != MODE_CAPT_PW && mode != MODE_CAPT_FRQPW)) begin
         pw_state <= PW_IDLE;
      end else begin
         case (pw_state)
            PW_IDLE: begin
               // A finished freq+pw sequence ignores edges until software is ready.
               if (ev.rise && !frqpw_done) begin
                  pw_state <= PW_HIGH;
               end
            end
            PW_HIGH: begin
               if (ev.fall) begin
                  pw_state <= PW_LOW;
               end
            end
            PW_LOW: begin
               // In freq+pw mode the closing rise ends the sequence instead of
               // starting a new width.
               if (ev.rise) begin
                  pw_state <= (mode == MODE_CAPT_FRQPW) ? PW_IDLE : PW_HIGH;
               end
            end
            default: pw_state <= PW_IDLE;
         endcase
      end
   end

   // Capture, restart and flag decisions per mode.
   always_comb begin
      capture_now = 1'b0;
      restart_now = 1'b0;
      flag_set = 1'b0;
      case (mode)
         MODE_PERIODIC: begin
            restart_now = tk.tick && (count_value == capture_compare_value); // [RULE_08]
            flag_set = restart_now;
         end
         MODE_TIMEOUT: begin
            restart_now = sel_edge && (!counting || !armed); // [RULE_10] [RULE_12]
            flag_set = tk.tick && counting && armed &&
                       (count_value == capture_compare_value); // [RULE_11]
         end
         MODE_CAPT_EVENT: begin
            capture_now = sel_edge; // [RULE_14]
            flag_set = sel_edge;
         end
         MODE_CAPT_FREQ: begin
            capture_now = sel_edge; // [RULE_19]
            restart_now = sel_edge;
            flag_set = sel_edge;
         end
         MODE_CAPT_PW: begin
            restart_now = run && ev.rise; // [RULE_20]
            capture_now = run && ev.fall && (pw_state == PW_HIGH);
            flag_set = capture_now;
         end
         MODE_CAPT_FRQPW: begin
            restart_now = run && ev.rise && (pw_state == PW_IDLE) && !frqpw_done;
            capture_now = run && ev.fall && (pw_state == PW_HIGH);
            flag_set = run && ev.rise && (pw_state == PW_LOW);
         end
         default: begin
            restart_now = tk.tick && (count_value == capture_compare_value);
         end
      endcase
   end

   // Counting indicator and timeout arming. [RULE_22]
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         counting <= 1'b0;
         armed <= 1'b0;
      end else if (!enable) begin
         counting <= 1'b0;
         armed <= 1'b0;
      end else if (mode == MODE_TIMEOUT) begin
         // Armed stays set once a sequence has begun, so a frozen counter waits
         // for an edge instead of running free as it does straight after enable.
         if (sel_edge) begin
            // First edge restarts and arms; second edge freezes. [RULE_10] [RULE_12]
            counting <= !(counting && armed);
            armed <= 1'b1;
         end else if (!armed) begin
            counting <= run;
         end
      end else if (mode == MODE_CAPT_FRQPW) begin
         if (restart_now) begin
            counting <= 1'b1;
         end else if (flag_set) begin
            counting <= 1'b0;
         end
      end else begin
         counting <= run;
         armed <= 1'b0;
      end
   end

   // Freq+pw mode waits for software after a sequence ends: a capture read
   // or a flag clear makes it ready to start again. Without this hold a late
   // rise would overwrite the result before software has seen it.
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         frqpw_done <= 1'b0;
      end else if (mode != MODE_CAPT_FRQPW || !run) begin
         frqpw_done <= 1'b0;
      end else if (flag_set) begin
         frqpw_done <= 1'b1;
      end else if (flag_clr || (rd_i && addr_i == CAPTURE_OFS)) begin
         frqpw_done <= 1'b0;
      end
   end

   // Next count; wraps from MAX to BOTTOM. [RULE_05] [RULE_09]
   // A compare value below the count is simply never met until the wrap,
   // which is how a lowered TOP avoids a spurious interrupt.
   always_comb begin
      next_count = count_value;
      if (restart_now) begin
         next_count = COUNT_BOTTOM;
      end else if (tk.tick && (counting || mode != MODE_TIMEOUT)) begin
         next_count = (count_value == COUNT_MAX) ? COUNT_BOTTOM : count_value + 16'h0001;
      end
   end

   // Count register; software write takes priority. Reads never touch it. [RULE_13]
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count_value <= COUNT_RST; // [RULE_01]
      end else if (wr_at(COUNT_OFS)) begin
         count_value <= wdata_i[CNT_W-1:0]; // [RULE_17]
      end else if (mode == MODE_CAPT_FRQPW && !counting && !restart_now) begin
         count_value <= count_value;
      end else begin
         count_value <= next_count;
      end
   end

   // Capture/compare register. [RULE_14] [RULE_19]
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         capture_compare_value <= CAPTURE_RST; // [RULE_01]
      end else if (capture_now) begin
         capture_compare_value <= count_value;
      end else if (wr_at(CAPTURE_OFS)) begin
         capture_compare_value <= wdata_i[CNT_W-1:0];
      end
   end

   // Flag: set wins over clear. High-byte read clears it in capture modes. [RULE_16]
   assign flag_clr = (rd_i && addr_i == CAPTURE_HI_OFS && is_capture_mode(mode)) ||
                     (wr_at(FLAGS_OFS) && wdata_i[FLAG_BIT]);

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flag <= 1'b0;
      end else if (flag_set) begin
         flag <= 1'b1;
      end else if (flag_clr) begin
         flag <= 1'b0;
      end
   end

   // Interrupt output follows the flag one cycle later, from a flip-flop. [RULE_23]
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= flag;
      end
   end

   // Read data, one cycle after the strobe; unmapped reads return zero.
   always_comb begin
      next_rdata = '0;
      case (addr_i)
         CONTROL_A_OFS: begin
            next_rdata[ENABLE_BIT] = enable;
            next_rdata[CLOCK_PRESCALE_SELECT_LSB +: CLOCK_PRESCALE_SELECT_W] = clock_prescale_select;
         end
         CONTROL_B_OFS: begin
            next_rdata[MODE_LSB +: MODE_W] = mode;
            next_rdata[EDGE_BIT] = edge_falling;
         end
         DEBUG_CONTROL_OFS: next_rdata[RUN_WHILE_HALTED_BIT] = run_while_halted;
         STATUS_OFS: next_rdata[RUN_BIT] = counting; // [RULE_22]
         FLAGS_OFS: next_rdata[FLAG_BIT] = flag;
         COUNT_OFS: next_rdata = count_value; // [RULE_07]
         CAPTURE_OFS: next_rdata = capture_compare_value;
         CAPTURE_HI_OFS: next_rdata = {8'h00, capture_compare_value[15:8]};
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= '0;
      end
   end
endmodule

//--- core/capture_timer_pkg.sv
// Shared constants and types of the capture timer.
package capture_timer_pkg;
   localparam int CNT_W = 16;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   // Register offsets.
   localparam logic [3:0] CONTROL_A_OFS = 4'h0;
   localparam logic [3:0] CONTROL_B_OFS = 4'h1;
   localparam logic [3:0] DEBUG_CONTROL_OFS = 4'h2;
   localparam logic [3:0] STATUS_OFS = 4'h3;
   localparam logic [3:0] FLAGS_OFS = 4'h4;
   localparam logic [3:0] COUNT_OFS = 4'h5;
   localparam logic [3:0] CAPTURE_OFS = 4'h6;
   localparam logic [3:0] CAPTURE_HI_OFS = 4'h7;
   // Control A fields.
   localparam int ENABLE_BIT = 0;
   localparam int CLOCK_PRESCALE_SELECT_LSB = 1;
   localparam int CLOCK_PRESCALE_SELECT_W = 2;
   // Control B fields.
   localparam int MODE_LSB = 0;
   localparam int MODE_W = 3;
   localparam int EDGE_BIT = 4;
   // Debug control and status fields.
   localparam int RUN_WHILE_HALTED_BIT = 0;
   localparam int RUN_BIT = 0;
   localparam int FLAG_BIT = 0;
   // Reset values.
   localparam logic [15:0] CONTROL_A_RST = 16'h0000;
   localparam logic [15:0] CONTROL_B_RST = 16'h0000;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] CAPTURE_RST = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
   // Prescaler: divide by 1, 2, 4 of the local prescaler, or companion tick.
   localparam logic [1:0] CLOCK_PRESCALE_SELECT_DIV1 = 2'h0;
   localparam logic [1:0] CLOCK_PRESCALE_SELECT_DIV2 = 2'h1;
   localparam logic [1:0] CLOCK_PRESCALE_SELECT_COMPANION = 2'h2;
   localparam logic [1:0] CLOCK_PRESCALE_SELECT_DIV4 = 2'h3;
   typedef enum logic [2:0] {
      MODE_PERIODIC = 3'h0,
      MODE_TIMEOUT = 3'h1,
      MODE_CAPT_EVENT = 3'h2,
      MODE_CAPT_FREQ = 3'h3,
      MODE_CAPT_PW = 3'h4,
      MODE_CAPT_FRQPW = 3'h5,
      MODE_SINGLE = 3'h6,
      MODE_PWM8 = 3'h7
   } mode_t;
   // Pulse width tracker states.
   typedef enum logic [2:0] {
      PW_IDLE = 3'b001,
      PW_HIGH = 3'b010,
      PW_LOW = 3'b100
   } pw_state_t;
endpackage

//--- core/count_prescaler.sv
// Local prescaler and count tick selector.
`timescale 1ns/10ps
module count_prescaler
   import capture_timer_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // Control.
   input wire logic run_i,
   input wire logic [1:0] clock_prescale_select_i,
   input wire logic companion_tick_i,
   // Tick out.
   tick_if.src tk
);
   logic [1:0] div;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div <= 2'h0;
      end else if (run_i) begin
         div <= div + 2'h1;
      end else begin
         div <= 2'h0;
      end
   end

   // The tick is one clock wide at the chosen rate. [RULE_03]
   always_comb begin
      case (clock_prescale_select_i)
         CLOCK_PRESCALE_SELECT_DIV1: tk.tick = run_i;
         CLOCK_PRESCALE_SELECT_DIV2: tk.tick = run_i && div[0];
         CLOCK_PRESCALE_SELECT_COMPANION: tk.tick = run_i && companion_tick_i;
         default: tk.tick = run_i && (div == 2'h3);
      endcase
   end
endmodule

//--- core/event_edge_detect.sv
// Synchroniser and edge detector for the event input.
`timescale 1ns/10ps
module event_edge_detect (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // Event in.
   input wire logic event_i,
   // Edges out.
   tick_if.src ev
);
   logic sync1;
   logic sync2;
   logic prev;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         prev <= 1'b0;
      end else begin
         sync1 <= event_i;
         sync2 <= sync1;
         prev <= sync2;
      end
   end

   assign ev.rise = sync2 && !prev; // [RULE_18]
   assign ev.fall = !sync2 && prev;
   assign ev.level = sync2;
endmodule

//--- core/tick_if.sv
// Tick and event signals between the timer core and its helpers.
`timescale 1ns/10ps
interface tick_if;
   logic tick;
   logic rise;
   logic fall;
   logic level;
   modport src (output tick, output rise, output fall, output level);
   modport dst (input tick, input rise, input fall, input level);
endinterface

//--- dv/capture_timer_assertions.sv
// Port-level checks of the capture timer.
`timescale 1ns/10ps
module capture_timer_assertions
   import capture_timer_pkg::*;
(
   // Clock, reset and register port.
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [DATA_W-1:0] rdata_o,
   // System side.
   input wire logic event_i,
   input wire logic debug_halt_i,
   input wire logic irq_o
);
   logic [2:0] mode;
   logic en;
   logic fall_sel;
   logic prev_ev;
   logic [3:0] quiet;
   logic [3:0] off_cnt;
   logic cap_mode;
   assign cap_mode = mode inside {3'h2, 3'h3, 3'h4, 3'h5};
   // Shadows of what software wrote, so edges can be tied to the active mode.
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode <= 3'h0;
         en <= 1'b0;
         fall_sel <= 1'b0;
      end else if (wr_i && addr_i == CONTROL_A_OFS) begin
         en <= wdata_i[ENABLE_BIT];
      end else if (wr_i && addr_i == CONTROL_B_OFS) begin
         mode <= wdata_i[2:0];
         fall_sel <= wdata_i[EDGE_BIT];
      end
   end
   // Cycles since the event last moved and since the timer was disabled.
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev_ev <= 1'b0;
         quiet <= 4'h0;
         off_cnt <= 4'h0;
      end else begin
         prev_ev <= event_i;
         quiet <= (event_i != prev_ev) ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
         off_cnt <= en ? 4'h0 : off_cnt + {3'h0, off_cnt != 4'hF};
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   idle_read_a: assert property (!rd_i |=> rdata_o == '0)
      else $error("read data outside a read");
   unmapped_read_a: assert property (
      rd_i && addr_i > CAPTURE_HI_OFS |=> rdata_o == '0)
      else $error("unmapped read not zero");
   high_byte_a: assert property (
      rd_i && addr_i == CAPTURE_HI_OFS |=> rdata_o[15:8] == 8'h00)
      else $error("high byte read has upper bits");
   status_bits_a: assert property (
      rd_i && addr_i == STATUS_OFS |=> rdata_o[15:1] == '0)
      else $error("status upper bits set");
   high_read_clear_a: assert property (
      cap_mode && rd_i && addr_i == CAPTURE_HI_OFS && quiet > 4'h6 ##1 $stable(event_i)
      |=> !irq_o)
      else $error("high byte read left irq set");
   irq_cause_a: assert property (
      $rose(irq_o) && mode == MODE_CAPT_EVENT |-> quiet < 4'h8)
      else $error("capture irq without an event");
   disabled_quiet_a: assert property (off_cnt > 4'h3 && !irq_o |=> !irq_o)
      else $error("irq raised while disabled");
   capture_delay_a: assert property (
      en && mode == MODE_CAPT_EVENT && !fall_sel && !debug_halt_i && !irq_o
      && quiet > 4'h6 ##1 $rose(event_i) |-> ##[2:5] irq_o)
      else $error("capture irq late or missing");
endmodule
bind capture_timer capture_timer_assertions capture_timer_assertions_i (
   .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .event_i(event_i),
   .debug_halt_i(debug_halt_i), .irq_o(irq_o));

//--- dv/capture_timer_tb.sv
// Self-checking bench of the capture timer.
`timescale 1ns/10ps
`define CHK(nm, ex, ac) begin num_checks++; if ((ac) !== (ex)) begin fails++; \
   $display("BAD %s exp %0h got %0h", nm, ex, ac); end end
module capture_timer_tb;
   import capture_timer_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [ADDR_W-1:0] addr_i = '0;
   logic [DATA_W-1:0] wdata_i = '0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic debug_halt_i = 1'b0;
   logic tick_en = 1'b0;
   logic [DATA_W-1:0] rdata_o;
   logic event_i;
   logic companion_tick_i;
   logic irq_o;
   logic [31:0] seed = 32'h8D006956;
   logic [15:0] a;
   logic [15:0] b;
   int fails = 0;
   int num_checks = 0;
   int cyc = 0;
   int n;
   int top;
   capture_timer capture_timer_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .event_i(event_i),
      .companion_tick_i(companion_tick_i), .debug_halt_i(debug_halt_i), .irq_o(irq_o));
   ev_model ev_model_i (.ref_clk_i(ref_clk_i), .tick_en_i(tick_en), .event_o(event_i),
      .tick_o(companion_tick_i));
   always #10 ref_clk_i = ~ref_clk_i;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic wr(input logic [3:0] ad, input logic [15:0] d);
      @(posedge ref_clk_i);
      addr_i <= ad;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] ad, output logic [15:0] q);
      @(posedge ref_clk_i);
      addr_i <= ad;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 q = rdata_o;
   endtask
   task automatic tk(input int k);
      repeat (k) @(posedge ref_clk_i);
      #1;
   endtask
   // Disable, program, zero the count and clear the flag before enabling.
   task automatic cfg(input logic [15:0] cb, input logic [15:0] tp, input logic [1:0] sel);
      wr(CONTROL_A_OFS, 16'h0000);
      wr(CONTROL_B_OFS, cb);
      wr(CAPTURE_OFS, tp);
      wr(COUNT_OFS, COUNT_BOTTOM);
      wr(FLAGS_OFS, 16'h0001);
      wr(CONTROL_A_OFS, {13'h0000, sel, 1'b1});
   endtask
   task automatic wait_irq(input int lim);
      n = 0;
      while (irq_o !== 1'b1 && n < lim) begin
         tk(1);
         n++;
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      repeat (4) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      rd(CAPTURE_OFS, a);
      `CHK("capture_compare_value", CAPTURE_RST, a)
      rd(4'hC, a);
      `CHK("unmapped", 16'h0000, a)
      for (int m = 0; m < 8; m++) begin
         rd(CONTROL_B_OFS, a);
         `CHK("mode", m == 0 ? CONTROL_B_RST : 16'(m - 1), a)
         wr(CONTROL_B_OFS, 16'(m));
      end
      $display("test registers done");
      // Div 1, 2, companion every third clock, div 4: period scales by i + 1.
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         top = 12 + seed[3:0];
         tick_en <= (i == 2);
         cfg(16'h0000, 16'(top), i[1:0]);
         wait_irq(top * 4 + 20);
         `CHK("period", 1'b1, n >= top * (i + 1) - i - 3 && n <= top * (i + 1) + 10)
         rd(COUNT_OFS, a);
         `CHK("restart", 1'b1, a <= top)
         wr(FLAGS_OFS, 16'h0001);
         tk(1);
         `CHK("irq clear", 1'b0, irq_o)
      end
      tick_en <= 1'b0;
      cfg(16'h0000, 16'h0010, CLOCK_PRESCALE_SELECT_DIV1);
      wr(COUNT_OFS, 16'h0100);
      wr(FLAGS_OFS, 16'h0001);
      tk(60);
      `CHK("above top", 1'b0, irq_o)
      rd(COUNT_OFS, a);
      `CHK("runs on", 1'b1, a > 16'h0100)
      $display("test periodic done");
      @(posedge ref_clk_i) debug_halt_i <= 1'b1;
      tk(4);
      rd(COUNT_OFS, a);
      tk(10);
      rd(COUNT_OFS, b);
      `CHK("halted", a, b)
      wr(DEBUG_CONTROL_OFS, 16'h0001);
      rd(COUNT_OFS, a);
      tk(10);
      rd(COUNT_OFS, b);
      `CHK("run halted", 1'b1, b > a)
      @(posedge ref_clk_i) debug_halt_i <= 1'b0;
      wr(DEBUG_CONTROL_OFS, 16'h0000);
      $display("test debug done");
      for (int e = 0; e < 2; e++) begin
         ev_model_i.drive(e[0], 8);
         cfg({11'h000, e[0], 4'h2}, 16'h0000, CLOCK_PRESCALE_SELECT_DIV1);
         tk(20);
         rd(COUNT_OFS, a);
         ev_model_i.drive(!e[0], 8);
         rd(CAPTURE_OFS, b);
         `CHK("capture", 1'b1, b - a >= 2 && b - a <= 12)
         `CHK("event irq", 1'b1, irq_o)
         rd(CAPTURE_HI_OFS, a);
         `CHK("high byte", {8'h00, b[15:8]}, a)
         tk(1);
         `CHK("auto clear", 1'b0, irq_o)
         ev_model_i.drive(e[0], 8);
         `CHK("other edge", 1'b0, irq_o)
      end
      for (int j = 0; j < 2; j++) begin
         seed = lfsr(seed);
         top = 20 + seed[4:0];
         ev_model_i.drive(1'b0, 4);
         cfg(16'h0003, 16'h0000, CLOCK_PRESCALE_SELECT_DIV1);
         ev_model_i.drive(1'b1, 4);
         ev_model_i.drive(1'b0, top - 4);
         ev_model_i.drive(1'b1, 6);
         rd(CAPTURE_OFS, a);
         `CHK("freq", 1'b1, a + 2 >= top && a <= top + 2)
         `CHK("freq irq", 1'b1, irq_o)
         ev_model_i.drive(1'b0, 4);
         cfg(16'h0004, 16'h0000, CLOCK_PRESCALE_SELECT_DIV1);
         ev_model_i.drive(1'b1, top);
         `CHK("pw wait", 1'b0, irq_o)
         ev_model_i.drive(1'b0, 6);
         rd(CAPTURE_OFS, a);
         `CHK("width", 1'b1, a + 2 >= top && a <= top + 2)
         `CHK("pw irq", 1'b1, irq_o)
      end
      cfg(16'h0005, 16'h0000, CLOCK_PRESCALE_SELECT_DIV1);
      ev_model_i.drive(1'b1, 10);
      ev_model_i.drive(1'b0, 10);
      `CHK("frqpw wait", 1'b0, irq_o)
      ev_model_i.drive(1'b1, 4);
      rd(CAPTURE_OFS, a);
      `CHK("frqpw width", 1'b1, a + 2 >= 10 && a <= 12)
      `CHK("frqpw irq", 1'b1, irq_o)
      ev_model_i.drive(1'b0, 4);
      cfg(16'h0001, 16'h001E, CLOCK_PRESCALE_SELECT_DIV1);
      ev_model_i.drive(1'b1, 4);
      ev_model_i.drive(1'b0, 50);
      `CHK("timeout", 1'b1, irq_o)
      wr(FLAGS_OFS, 16'h0001);
      ev_model_i.drive(1'b1, 6);
      rd(STATUS_OFS, a);
      `CHK("stopped", 16'h0000, a)
      rd(COUNT_OFS, a);
      rd(CAPTURE_OFS, b);
      wr(STATUS_OFS, 16'h0001);
      rd(COUNT_OFS, b);
      `CHK("frozen", a, b)
      ev_model_i.drive(1'b0, 4);
      ev_model_i.drive(1'b1, 6);
      rd(STATUS_OFS, a);
      `CHK("restart", 16'h0001, a)
      ev_model_i.drive(1'b0, 4);
      ev_model_i.drive(1'b1, 6);
      `CHK("early stop", 1'b0, irq_o)
      wr(CONTROL_A_OFS, 16'h0000);
      $display("test capture modes done");
      wrap_up();
   end
endmodule

//--- dv/ev_model.sv
// Model of the event routing fabric and the companion timer tick.
`timescale 1ns/10ps
module ev_model (
   // Clock and bench control.
   input wire logic ref_clk_i,
   input wire logic tick_en_i,
   // Toward the timer.
   output logic event_o,
   output logic tick_o
);
   logic [1:0] phase;
   initial begin
      phase = 2'h0;
      event_o = 1'b0;
      tick_o = 1'b0;
   end
   // A one-cycle tick every third clock stands for the companion prescaler.
   always @(posedge ref_clk_i) begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      tick_o <= tick_en_i && phase == 2'h2;
   end
   // Levels are held whole cycles and never under two, so no edge is lost.
   task automatic drive(input logic lvl, input int hold);
      @(posedge ref_clk_i);
      event_o <= lvl;
      repeat ((hold < 2) ? 1 : hold - 1) @(posedge ref_clk_i);
      #1;
   endtask
endmodule
